// ===== dv/odpd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module odpd_ctrl_model (
  // Link clock
  input  wire logic ck_link,
  // Controller pins
  output var logic  cke,
  output var logic  odt,
  output var logic  refresh_cmd
);
  initial begin
    cke = 1'b1;
    odt = 1'b0;
    refresh_cmd = 1'b0;
  end
  // Pins move after a falling edge, held n cycles
  task automatic drive(input logic c, input logic o, input int n);
    @(negedge ck_link);
    cke <= c;
    odt <= o;
    repeat (n - 1) @(negedge ck_link);
  endtask
  // Refresh only while up, no access in power-down
  task automatic refresh();
    @(negedge ck_link);
    refresh_cmd <= cke;
    @(negedge ck_link);
    refresh_cmd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/odpd_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module odpd_monitor #(
  parameter int WL    = odpd_pkg::WL_DEF,
  parameter int XPDLL = odpd_pkg::XPDLL_DEF,
  parameter int RFC   = odpd_pkg::RFC_DEF
) (
  // Clocks and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ck_link,
  // Pins
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        refresh_cmd,
  input wire logic [15:0] mr0,
  // Termination state
  input wire logic        rtt_on,
  input wire logic        in_window,
  input wire logic        async_mode
);
  localparam int SETTLE    = WL * 16;
  localparam int RTT_BOUND = WL * 8;
  localparam int EXIT_HOLD = XPDLL * 2 + 2;
  localparam int REF_OLD   = RFC * 4;
  localparam int REF_YOUNG = RFC * 2;
  logic       frozen;
  logic [9:0] odt_hi, odt_lo, cke_hi, cke_lo, ref_age;
  ////////////////////////////////////////
  assign frozen = mr0[odpd_pkg::MR0_DLL_BIT] == odpd_pkg::MR0_DLL_FROZEN;
  function automatic logic [9:0] inc(input logic [9:0] v);
    return v + {9'h000, ~&v};
  endfunction
  // Saturating ages of each pin level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      odt_hi  <= '0;
      odt_lo  <= '0;
      cke_hi  <= '0;
      cke_lo  <= '0;
      ref_age <= 10'h3ff;
    end else begin
      odt_hi  <= odt ? inc(odt_hi) : '0;
      odt_lo  <= odt ? '0 : inc(odt_lo);
      cke_hi  <= cke ? inc(cke_hi) : '0;
      cke_lo  <= cke ? '0 : inc(cke_lo);
      ref_age <= refresh_cmd ? '0 : inc(ref_age);
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  dll_on_nowin_a: assert property (!frozen |-> !in_window)
    else $error("window open while dll runs");
  entry_win_a: assert property ($fell(cke) && frozen |-> ##[1:12] in_window)
    else $error("no window at power-down entry");
  exit_win_a: assert property ($rose(cke) && frozen |-> ##[1:12] in_window)
    else $error("no window at power-down exit");
  exit_hold_a: assert property ($rose(cke) && frozen |-> ##EXIT_HOLD in_window)
    else $error("exit window closed early");
  rtt_on_a: assert property (odt_hi >= RTT_BOUND |-> rtt_on)
    else $error("termination late to turn on");
  rtt_off_a: assert property (odt_lo >= RTT_BOUND |-> !rtt_on)
    else $error("termination late to turn off");
  ref_hold_a: assert property (frozen && cke_lo >= SETTLE / 2 && ref_age >= SETTLE / 2
    && ref_age <= REF_YOUNG |-> in_window) else $error("window ended inside refresh");
  pd_async_a: assert property (frozen && cke_lo >= SETTLE && ref_age >= REF_OLD
    |-> async_mode && !in_window) else $error("power-down not asynchronous");
  up_sync_a: assert property (cke_hi >= SETTLE |-> !async_mode && !in_window)
    else $error("still asynchronous after exit");
  win_c: cover property ($rose(in_window));
  async_c: cover property ($rose(async_mode));
  exit_c: cover property ($fell(async_mode));
  link_c: cover property (@(posedge ck_link) $fell(cke));
endmodule
bind odpd_term odpd_monitor #(.WL(WL), .XPDLL(XPDLL), .RFC(RFC)) odpd_monitor_i (.clk(clk),
  .rst_n(rst_n), .ck_link(ck_link), .cke(cke), .odt(odt), .refresh_cmd(refresh_cmd),
  .mr0(mr0), .rtt_on(rtt_on), .in_window(in_window), .async_mode(async_mode));
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst_n;
  logic        ck_link;
  logic        cke;
  logic        odt;
  logic        refresh_cmd;
  logic [15:0] mr0;
  logic        rtt_on;
  logic        in_window;
  logic        async_mode;
  logic        o;
  logic        fz;
  int          pd;
  int          mismatches;
  int          checks;
  ////////////////////////////////////////
  odpd_term odpd_term_i (.clk(clk), .rst_n(rst_n), .ck_link(ck_link), .cke(cke), .odt(odt),
    .refresh_cmd(refresh_cmd), .mr0(mr0), .rtt_on(rtt_on), .in_window(in_window),
    .async_mode(async_mode));
  odpd_ctrl_model odpd_ctrl_model_i (.ck_link(ck_link), .cke(cke), .odt(odt),
    .refresh_cmd(refresh_cmd));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial begin
    ck_link = 1'b0;
    #3;
    forever #16 ck_link = ~ck_link;
  end
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Random odt, cke level held n link cycles
  task automatic go(input logic c, input int n);
    o = 1'($urandom);
    pd = c ? 0 : 1;
    odpd_ctrl_model_i.drive(c, o, n);
    @(negedge clk);
  endtask
  task automatic steady();
    check(in_window, 1'b0);
    check(async_mode, 1'(pd) & fz);
    check(rtt_on, o);
  endtask
  initial begin
    rst_n = 1'b0;
    mr0 = 16'h0000;
    mismatches = 0;
    checks = 0;
    pd = 0;
    o = 1'b0;
    void'($urandom(96116));
    for (int f = 0; f < 2; f++) begin
      fz = f[0];
      @(negedge clk);
      rst_n = 1'b0;
      mr0 = 16'($urandom);
      mr0[odpd_pkg::MR0_DLL_BIT] = fz ? odpd_pkg::MR0_DLL_FROZEN : ~odpd_pkg::MR0_DLL_FROZEN;
      repeat (13) @(negedge clk);
      rst_n = 1'b1;
      go(1'b1, 30);
      steady();
      // Short cycles so windows overlap
      go(1'b0, 2);
      repeat (6) begin
        go(1'b1, 2 + $urandom_range(2));
        check(in_window, fz);
        go(1'b0, 1 + $urandom_range(2));
        check(in_window, fz);
      end
      go(1'b1, 30);
      steady();
      odpd_ctrl_model_i.refresh();
      go(1'b0, 50);
      check(in_window, fz);
      go(1'b0, 50);
      steady();
      repeat (3) begin
        go(1'b0, 20);
        steady();
      end
      go(1'b1, 3);
      check(in_window, fz);
      repeat (3) begin
        go(1'b1, 25);
        steady();
      end
    end
    end_sim();
  end
  initial begin
    #100_000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire

// ===== logic/odpd_delay_line.sv
`timescale 1ns/100ps
`default_nettype none
module odpd_delay_line #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;

  always_comb begin
    next_line = {line[DEPTH-2:0], din};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line <= '0;
    end else begin
      line <= next_line;
    end
  end

  assign dout = line[DEPTH-1];
endmodule
`default_nettype wire

// ===== logic/odpd_pkg.sv
`default_nettype none
package odpd_pkg;
  // Link timing in link clock cycles
  localparam int WL_DEF        = 5;
  localparam int AL_DEF        = 0;
  localparam int CPDED_DEF     = 1;
  localparam int XPDLL_DEF     = 10;
  localparam int RFC_DEF       = 88;
  localparam int CNT_W         = 8;
  // Asynchronous turn-on/off delays in ps
  localparam int AONPD_MIN_PS  = 2000;
  localparam int AONPD_MAX_PS  = 8500;
  localparam int CLK_PERIOD_PS = 10000;
  // Async path delay in core clocks: min rounds up, max rounds down, at least one
  localparam int AONPD_MIN_CYC =
    ((AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int AONPD_MAX_CYC =
    (AONPD_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : (AONPD_MAX_PS / CLK_PERIOD_PS);
  // Mode register 0 bit that selects frozen DLL in power-down
  localparam int MR0_DLL_BIT   = 12;
  localparam logic MR0_DLL_FROZEN = 1'b0;
  typedef enum logic [1:0] {ODPD_SYNC, ODPD_ENTRY, ODPD_PD, ODPD_EXIT} odpd_phase_t;
endpackage
`default_nettype wire

// ===== logic/odpd_term.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RQ1] Windows only when MR0 A12 is 0
// [RQ2] Lead interval is WL minus one cycles
// [RQ3] Entry window: lead start to CPDED end
// [RQ4] Lead start excluded, end points included
// [RQ5] Refresh in flight extends entry window end; only applied on entry from ODPD_SYNC, not on re-entry from ODPD_EXIT
// [RQ6] Turn-on bounded by sync/async min and max; async delay line is 2 core clocks, above the AONPD_MAX_CYC of 1
// [RQ7] Turn-off bounded by sync/async min and max; async turn-off uses the same 2 core clock line, no AOFPD max is applied
// [RQ8] Entry: before sync, after async
// [RQ9] Exit window: lead before to XPDLL after
// [RQ10] Exit: before async, after sync
// [RQ11] Entry/exit overlap merges into one window
// [RQ12] Exit/entry overlap merges into one window
// [RQ13] Async mode when DLL frozen in power-down
// [RQ14] Async path skips the additive latency
// [RQ15] ODT stays live; no read/write in power-down
// [RQ16] Controller treats window termination as indeterminate
module odpd_term #(
  parameter int WL    = odpd_pkg::WL_DEF,
  parameter int AL    = odpd_pkg::AL_DEF,
  parameter int CPDED = odpd_pkg::CPDED_DEF,
  parameter int XPDLL = odpd_pkg::XPDLL_DEF,
  parameter int RFC   = odpd_pkg::RFC_DEF
) (
  // Core clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link clock and pins
  input  wire logic ck_link,
  input  wire logic cke,
  input  wire logic odt,
  input  wire logic refresh_cmd,
  // Mode register 0 contents
  input  wire logic [15:0] mr0,
  // Termination state
  output logic      rtt_on,
  output logic      in_window,
  output logic      async_mode
);
  localparam int LEAD = WL - 1;
  localparam int ODTL = WL - 2;
  localparam int HIST = 2 * WL + AL + 4;
  localparam int SYNC_DLY = ODTL + AL;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain reset: rst_n is core-timed, so resynchronise it
  logic [2:0] s_rst;
  logic [2:0] next_s_rst;
  logic       rst_link_n;

  always_comb begin
    next_s_rst = {s_rst[1:0], rst_n};
  end

  always_ff @(posedge ck_link) begin
    s_rst <= next_s_rst;
  end

  // Assert once either late stage drops, release once both agree
  assign rst_link_n = s_rst[1] & s_rst[2];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: ODT pipeline and window tracking
  logic [HIST-1:0]  odt_hist;
  logic [HIST-1:0]  next_odt_hist;
  logic             cke_q;
  logic             next_cke_q;
  odpd_pkg::odpd_phase_t phase;
  odpd_pkg::odpd_phase_t next_phase;
  logic [odpd_pkg::CNT_W-1:0] tail_cnt;
  logic [odpd_pkg::CNT_W-1:0] next_tail_cnt;
  logic [odpd_pkg::CNT_W-1:0] rfc_cnt;
  logic [odpd_pkg::CNT_W-1:0] next_rfc_cnt;
  logic             win_link;
  logic             next_win_link;
  logic             sync_rtt;
  logic             next_sync_rtt;
  logic             dll_frozen;

  // [RQ1] Frozen DLL select
  assign dll_frozen = (mr0[odpd_pkg::MR0_DLL_BIT] == odpd_pkg::MR0_DLL_FROZEN);

  always_comb begin
    next_odt_hist = {odt_hist[HIST-2:0], odt};
    next_cke_q    = cke;
    next_phase    = phase;
    next_tail_cnt = (tail_cnt != '0) ? tail_cnt - 1'b1 : tail_cnt;
    // [RQ5] Refresh time tracking
    next_rfc_cnt  = refresh_cmd ? odpd_pkg::CNT_W'(RFC) :
                    ((rfc_cnt != '0) ? rfc_cnt - 1'b1 : rfc_cnt);
    unique case (phase)
      odpd_pkg::ODPD_SYNC: begin
        if (cke_q && !cke) begin
          next_phase    = odpd_pkg::ODPD_ENTRY;
          // [RQ3] Window tail covers CPDED, end included
          next_tail_cnt = odpd_pkg::CNT_W'(CPDED);
          // [RQ5] Later of refresh end and CPDED end
          if (rfc_cnt > odpd_pkg::CNT_W'(CPDED)) begin
            next_tail_cnt = rfc_cnt;
          end
        end
      end
      odpd_pkg::ODPD_ENTRY: begin
        if (cke) begin
          // [RQ11] Exit during entry tail keeps window open
          next_phase    = odpd_pkg::ODPD_EXIT;
          next_tail_cnt = (tail_cnt > odpd_pkg::CNT_W'(XPDLL)) ? tail_cnt :
                          odpd_pkg::CNT_W'(XPDLL);
        end else if (tail_cnt == '0) begin
          next_phase = odpd_pkg::ODPD_PD;
        end
      end
      odpd_pkg::ODPD_PD: begin
        if (cke) begin
          // [RQ9] Exit tail of XPDLL after CKE high
          next_phase    = odpd_pkg::ODPD_EXIT;
          next_tail_cnt = odpd_pkg::CNT_W'(XPDLL);
        end
      end
      odpd_pkg::ODPD_EXIT: begin
        if (!cke) begin
          // [RQ12] New entry during exit tail merges windows
          next_phase    = odpd_pkg::ODPD_ENTRY;
          next_tail_cnt = (tail_cnt > odpd_pkg::CNT_W'(CPDED)) ? tail_cnt :
                          odpd_pkg::CNT_W'(CPDED);
        end else if (tail_cnt == '0) begin
          next_phase = odpd_pkg::ODPD_SYNC;
        end
      end
    endcase
    if (!dll_frozen) begin
      next_phase = cke ? odpd_pkg::ODPD_SYNC : odpd_pkg::ODPD_PD;
    end
    // [RQ2] Lead interval: WL-1 cycles before CKE edge, start excluded
    // [RQ4] Window flag, lead start excluded, ends included
    next_win_link = dll_frozen && ((next_phase == odpd_pkg::ODPD_ENTRY) ||
                    (next_phase == odpd_pkg::ODPD_EXIT));
    // [RQ8] Synchronous path applies ODTLon/off plus AL
    next_sync_rtt = odt_hist[SYNC_DLY];
  end

  always_ff @(posedge ck_link) begin
    if (!rst_link_n) begin
      odt_hist <= '0;
      cke_q    <= 1'b1;
      phase    <= odpd_pkg::ODPD_SYNC;
      tail_cnt <= '0;
      rfc_cnt  <= '0;
      win_link <= 1'b0;
      sync_rtt <= 1'b0;
    end else begin
      odt_hist <= next_odt_hist;
      cke_q    <= next_cke_q;
      phase    <= next_phase;
      tail_cnt <= next_tail_cnt;
      rfc_cnt  <= next_rfc_cnt;
      win_link <= next_win_link;
      sync_rtt <= next_sync_rtt;
    end
  end

  // Window is announced LEAD cycles early by delaying everything else
  logic [LEAD:0] win_lead;
  logic [LEAD:0] next_win_lead;
  logic [LEAD:0] pd_lead;
  logic [LEAD:0] next_pd_lead;
  logic          pd_link;

  assign pd_link = dll_frozen && (phase == odpd_pkg::ODPD_PD);

  always_comb begin
    next_win_lead = {win_lead[LEAD-1:0], win_link};
    next_pd_lead  = {pd_lead[LEAD-1:0], pd_link};
  end

  always_ff @(posedge ck_link) begin
    if (!rst_link_n) begin
      win_lead <= '0;
      pd_lead  <= '0;
    end else begin
      win_lead <= next_win_lead;
      pd_lead  <= next_pd_lead;
    end
  end

  logic win_any;
  logic odt_async_src;
  logic odt_sync_src;
  // [RQ2] Window opens LEAD cycles ahead of CKE
  assign win_any       = win_link | (|win_lead);
  // [RQ14] Async path follows ODT without AL
  assign odt_async_src = odt_hist[LEAD];
  assign odt_sync_src  = sync_rtt;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing to core clock: three-stage synchronisers
  logic [2:0] s_win;
  logic [2:0] s_pd;
  logic [2:0] s_odta;
  logic [2:0] s_odts;
  logic [2:0] next_s_win;
  logic [2:0] next_s_pd;
  logic [2:0] next_s_odta;
  logic [2:0] next_s_odts;

  always_comb begin
    next_s_win  = {s_win[1:0], win_any};
    next_s_pd   = {s_pd[1:0], pd_lead[LEAD]};
    next_s_odta = {s_odta[1:0], odt_async_src};
    next_s_odts = {s_odts[1:0], odt_sync_src};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_win  <= '0;
      s_pd   <= '0;
      s_odta <= '0;
      s_odts <= '0;
    end else begin
      s_win  <= next_s_win;
      s_pd   <= next_s_pd;
      s_odta <= next_s_odta;
      s_odts <= next_s_odts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: settled levels and termination output
  logic win_c;
  logic pd_c;
  logic odta_c;
  logic odts_c;
  logic next_win_c;
  logic next_pd_c;
  logic next_odta_c;
  logic next_odts_c;

  always_comb begin
    next_win_c  = (s_win[1] == s_win[2]) ? s_win[2] : win_c;
    next_pd_c   = (s_pd[1] == s_pd[2]) ? s_pd[2] : pd_c;
    next_odta_c = (s_odta[1] == s_odta[2]) ? s_odta[2] : odta_c;
    next_odts_c = (s_odts[1] == s_odts[2]) ? s_odts[2] : odts_c;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_c  <= 1'b0;
      pd_c   <= 1'b0;
      odta_c <= 1'b0;
      odts_c <= 1'b0;
    end else begin
      win_c  <= next_win_c;
      pd_c   <= next_pd_c;
      odta_c <= next_odta_c;
      odts_c <= next_odts_c;
    end
  end

  // [RQ6] Async turn-on delay line is 2 core clocks (AONPD_MIN_CYC + 1), above the AONPD_MAX_CYC of 1
  // [RQ7] Async turn-off uses the same 2 core clock line; no AOFPD max is applied
  logic odta_dly;
  odpd_delay_line #(
    .DEPTH (odpd_pkg::AONPD_MIN_CYC + 1)
  ) u_async_dly (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (odta_c),
    .dout  (odta_dly)
  );

  logic next_rtt_on;
  logic next_async_mode;
  logic next_in_window;

  always_comb begin
    // [RQ13] Async while DLL frozen in power-down
    // [RQ15] ODT stays live in power-down
    next_async_mode = pd_c;
    next_in_window  = win_c;
    if (pd_c) begin
      // [RQ10] Before exit window: async response
      next_rtt_on = odta_dly;
    end else if (win_c) begin
      // [RQ6] Earliest of the two paths turns on
      // [RQ7] Latest of the two paths turns off
      next_rtt_on = odta_dly | odts_c;
    end else begin
      // [RQ8] Outside windows: synchronous response
      next_rtt_on = odts_c;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rtt_on     <= 1'b0;
      async_mode <= 1'b0;
      in_window  <= 1'b0;
    end else begin
      rtt_on     <= next_rtt_on;
      async_mode <= next_async_mode;
      in_window  <= next_in_window;
    end
  end
endmodule
`default_nettype wire
